//--- shared/acsl_consts.svh
`ifndef ACSL_CONSTS_SVH
`define ACSL_CONSTS_SVH

// Register window and word offsets
`define ACSL_REG_BASE        32'h1380_0000
`define ACSL_OFS_CTRL        4'h0
`define ACSL_OFS_LOCK        4'h4
`define ACSL_OFS_TRY1        4'h8
`define ACSL_OFS_TRY2        4'hC

// Control register fields
`define ACSL_CTRL_SLEEP_BIT  31
`define ACSL_CTRL_WAKE_BIT   2
`define ACSL_CTRL_PULSE_BIT  1
`define ACSL_CTRL_RESET_BIT  0

// Reset values
`define ACSL_RST_WAKE_ONLY   1'b0
`define ACSL_RST_SOFT_RESET  1'b1
`define ACSL_RST_LOCK        2'h0

// Start address after reset or non-maskable exception
`define ACSL_BOOT_VECTOR     32'hF400_8000

// Scratch memory windows (32 KB each)
`define ACSL_WIN_LOCAL       32'hF400_0000
`define ACSL_WIN_ALT         32'hF400_8000
`define ACSL_WIN_PHYS        32'h1380_8000

`endif

//--- shared/acsl_pkg.sv
package acsl_pkg;

	// Registers known to the bus slave
	typedef enum logic [2:0] {
		ACSL_REG_CTRL,
		ACSL_REG_LOCK,
		ACSL_REG_TRY1,
		ACSL_REG_TRY2,
		ACSL_REG_NONE
	} acsl_reg_t;

	// Response sequencer of the bus slave
	typedef enum logic [1:0] {
		ACSL_RSP_OKAY,
		ACSL_RSP_ERR_FIRST,
		ACSL_RSP_ERR_LAST
	} acsl_rsp_t;

endpackage

//--- verilog/acsl_scratch_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "acsl_consts.svh"

module acsl_scratch_map #(
	parameter int BANKS   = 4,
	parameter int BANK_AW = 13
) (
	input  wire logic [31:0]              addr,
	input  wire logic                     req,
	input  wire logic                     from_aux,
	output logic                          hit,
	output logic [$clog2(BANKS)-1:0]      bank,
	output logic [BANK_AW-1:0]            offset
);

	localparam int WIN_AW = BANK_AW + $clog2(BANKS);
	localparam int HI_W   = 32 - WIN_AW;

	localparam logic [HI_W-1:0] LOCAL_HI = HI_W'(`ACSL_WIN_LOCAL >> WIN_AW);
	localparam logic [HI_W-1:0] ALT_HI   = HI_W'(`ACSL_WIN_ALT >> WIN_AW);
	localparam logic [HI_W-1:0] PHYS_HI  = HI_W'(`ACSL_WIN_PHYS >> WIN_AW);

	logic in_local;
	logic in_alt;
	logic in_phys;

	// No translation: the issued address itself selects the window
	always_comb begin
		in_local = addr[31:WIN_AW] == LOCAL_HI;
		in_alt   = addr[31:WIN_AW] == ALT_HI;
		in_phys  = addr[31:WIN_AW] == PHYS_HI;
		// Local window belongs to the helper core alone
		hit = req && (in_alt || in_phys || (from_aux && in_local));
		// Each window base is window aligned, so low bits give bank and offset
		bank   = addr[WIN_AW-1:BANK_AW];
		offset = addr[BANK_AW-1:0];
	end

endmodule
`default_nettype wire

//--- verilog/acsl_aux_ctrl.sv
// Contract
// - Control bit 31 reads helper sleep status
// - Wake-only set: pulse wakes, no exception
// - Wake-only clear: pulse wakes and raises exception
// - Bit 1 write one pulses; reads zero
// - Bit 0 holds core in reset; resets one
// - Reset and exception start at fixed vector
// - Executed wait instruction sets sleep flag
// - Wake-only wake resumes after wait instruction
// - Control bits 30 to 3 read zero
// - Try-one read loads lock if free
// - Try read returns updated lock word
// - Try write stores value only
// - Try-two behaves like try-one
// - Registers decoded from fixed base address
// - Scratch visible at physical and alternate windows
// - Local window reserved for helper core
// - Four 8 KB banks mapped consecutively
// - Different banks may be accessed concurrently
// - Helper addresses used without translation
`timescale 1ns/1ps
`default_nettype none
`include "acsl_consts.svh"

module acsl_aux_ctrl
	import acsl_pkg::*;
#(
	parameter int LOCK_W  = 2,
	parameter int BANKS   = 4,
	parameter int BANK_AW = 13
) (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RST,
	input  wire logic                     CE,
	// Register bus (AHB-Lite slave)
	input  wire logic                     HSEL,
	input  wire logic [31:0]              HADDR,
	input  wire logic [1:0]               HTRANS,
	input  wire logic                     HWRITE,
	input  wire logic [2:0]               HSIZE,
	input  wire logic [31:0]              HWDATA,
	input  wire logic                     HREADY,
	output logic [31:0]                   HRDATA,
	output logic                          HREADYOUT,
	output logic                          HRESP,
	// Helper core control
	input  wire logic                     AUX_WAIT_EXEC,
	output logic                          AUX_RESET,
	output logic                          AUX_WAKE,
	output logic                          AUX_NMI,
	output logic                          AUX_RESUME_NEXT,
	output logic [31:0]                   AUX_BOOT_VECTOR,
	// Scratch memory address mapping
	input  wire logic                     AUX_MEM_REQ,
	input  wire logic [31:0]              AUX_MEM_ADDR,
	input  wire logic                     SYS_MEM_REQ,
	input  wire logic [31:0]              SYS_MEM_ADDR,
	output logic                          AUX_MEM_HIT,
	output logic [$clog2(BANKS)-1:0]      AUX_MEM_BANK,
	output logic [BANK_AW-1:0]            AUX_MEM_OFFSET,
	output logic                          SYS_MEM_HIT,
	output logic                          SYS_MEM_STALL,
	output logic [$clog2(BANKS)-1:0]      SYS_MEM_BANK,
	output logic [BANK_AW-1:0]            SYS_MEM_OFFSET
);

	localparam int BW = $clog2(BANKS);
	// Register window base without its word offset bits
	localparam logic [27:0] REG_BASE_HI = 28'(`ACSL_REG_BASE >> 4);

	if (LOCK_W < 1 || LOCK_W > 30) begin : g_chk_lock
		$error("LOCK_W must be 1 to 30");
	end
	if (BANKS < 2 || (BANKS & (BANKS - 1)) != 0 || BANK_AW + BW > 16) begin : g_chk_map
		$error("BANKS must be a power of two and the window at most 64 KB");
	end

	// Claim the lock word for a try value only while it is free
	function automatic logic [LOCK_W-1:0] lock_claim(
		input logic [LOCK_W-1:0] lock,
		input logic [LOCK_W-1:0] try_val
	);
		lock_claim = (lock == '0) ? try_val : lock;
	endfunction

	// Misaligned or outside the four words: bus error
	function automatic acsl_reg_t reg_decode(input logic [31:0] addr);
		reg_decode = ACSL_REG_NONE;
		if (addr[31:4] == REG_BASE_HI && addr[1:0] == 2'b00) begin
			case (addr[3:0])
				`ACSL_OFS_CTRL: reg_decode = ACSL_REG_CTRL;
				`ACSL_OFS_LOCK: reg_decode = ACSL_REG_LOCK;
				`ACSL_OFS_TRY1: reg_decode = ACSL_REG_TRY1;
				`ACSL_OFS_TRY2: reg_decode = ACSL_REG_TRY2;
				default:        reg_decode = ACSL_REG_NONE;
			endcase
		end
	endfunction

	// Bus and register state
	acsl_rsp_t         rsp_q, rsp_d;
	acsl_reg_t         wr_reg_q, wr_reg_d;
	logic              wr_pend_q, wr_pend_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              wake_only_q, wake_only_d;
	logic              soft_reset_q, soft_reset_d;
	logic              sleep_q, sleep_d;
	logic [LOCK_W-1:0] lock_q, lock_d;
	logic [LOCK_W-1:0] try1_q, try1_d;
	logic [LOCK_W-1:0] try2_q, try2_d;
	logic              wake_q, wake_d;
	logic              nmi_q, nmi_d;
	logic              resume_q, resume_d;
	// Constant, yet registered so every output leaves a flip-flop
	logic [31:0]       vector_q;

	logic              accept;
	logic              pulse_req;
	acsl_reg_t         a_reg;

	always_comb begin
		rsp_d        = ACSL_RSP_OKAY;
		wr_reg_d     = wr_reg_q;
		wr_pend_d    = 1'b0;
		rdata_d      = 32'h0000_0000;
		wake_only_d  = wake_only_q;
		soft_reset_d = soft_reset_q;
		lock_d       = lock_q;
		try1_d       = try1_q;
		try2_d       = try2_q;
		pulse_req    = 1'b0;

		// Data phase of a write: HWDATA is valid now
		if (wr_pend_q) begin
			case (wr_reg_q)
				ACSL_REG_CTRL: begin
					wake_only_d  = HWDATA[`ACSL_CTRL_WAKE_BIT];
					soft_reset_d = HWDATA[`ACSL_CTRL_RESET_BIT];
					pulse_req    = HWDATA[`ACSL_CTRL_PULSE_BIT];
				end
				ACSL_REG_LOCK: lock_d = HWDATA[LOCK_W-1:0];
				ACSL_REG_TRY1: try1_d = HWDATA[LOCK_W-1:0];
				ACSL_REG_TRY2: try2_d = HWDATA[LOCK_W-1:0];
				default: ;
			endcase
		end

		// Address phase; reads see the write just completing via the _d values
		accept = HSEL && HREADY && HTRANS[1];
		a_reg  = reg_decode(HADDR);
		if (rsp_q == ACSL_RSP_ERR_FIRST) begin
			rsp_d = ACSL_RSP_ERR_LAST;
		end else if (accept) begin
			if (a_reg == ACSL_REG_NONE) begin
				rsp_d = ACSL_RSP_ERR_FIRST;
			end else if (HWRITE) begin
				wr_pend_d = 1'b1;
				wr_reg_d  = a_reg;
			end else begin
				// Read-modify happens here in one cycle, so no other access can interleave
				case (a_reg)
					ACSL_REG_CTRL: begin
						rdata_d[`ACSL_CTRL_SLEEP_BIT] = sleep_q;
						rdata_d[`ACSL_CTRL_WAKE_BIT]  = wake_only_d;
						rdata_d[`ACSL_CTRL_RESET_BIT] = soft_reset_d;
					end
					ACSL_REG_LOCK: rdata_d[LOCK_W-1:0] = lock_d;
					ACSL_REG_TRY1: begin
						lock_d              = lock_claim(lock_d, try1_d);
						rdata_d[LOCK_W-1:0] = lock_d;
					end
					ACSL_REG_TRY2: begin
						lock_d              = lock_claim(lock_d, try2_d);
						rdata_d[LOCK_W-1:0] = lock_d;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rsp_q        <= ACSL_RSP_OKAY;
			wr_reg_q     <= ACSL_REG_NONE;
			wr_pend_q    <= 1'b0;
			rdata_q      <= 32'h0000_0000;
			wake_only_q  <= `ACSL_RST_WAKE_ONLY;
			soft_reset_q <= `ACSL_RST_SOFT_RESET;
			lock_q       <= LOCK_W'(`ACSL_RST_LOCK);
			try1_q       <= '0;
			try2_q       <= '0;
		end else if (CE) begin
			rsp_q        <= rsp_d;
			wr_reg_q     <= wr_reg_d;
			wr_pend_q    <= wr_pend_d;
			rdata_q      <= rdata_d;
			wake_only_q  <= wake_only_d;
			soft_reset_q <= soft_reset_d;
			lock_q       <= lock_d;
			try1_q       <= try1_d;
			try2_q       <= try2_d;
		end
	end

	// Response flags registered so no bus output is decoded from state
	logic              hready_q, hready_d;
	logic              hresp_q, hresp_d;

	always_comb begin
		hready_d = (rsp_d != ACSL_RSP_ERR_FIRST);
		hresp_d  = (rsp_d != ACSL_RSP_OKAY);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			hready_q <= 1'b1;
			hresp_q  <= 1'b0;
		end else if (CE) begin
			hready_q <= hready_d;
			hresp_q  <= hresp_d;
		end
	end

	// Helper core wake, exception and sleep tracking
	always_comb begin
		// A pulse is sent even while the core is held in reset
		wake_d   = pulse_req;
		nmi_d    = pulse_req && !wake_only_d;
		// Core continues after its wait when only woken
		resume_d = pulse_req && wake_only_d;
		sleep_d  = sleep_q;
		if (pulse_req || soft_reset_q) begin
			sleep_d = 1'b0;
		end
		// A wait reported in the cycle of a wake still puts the core to sleep
		if (AUX_WAIT_EXEC && !soft_reset_q) begin
			sleep_d = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wake_q   <= 1'b0;
			nmi_q    <= 1'b0;
			resume_q <= 1'b0;
			sleep_q  <= 1'b0;
			vector_q <= `ACSL_BOOT_VECTOR;
		end else if (CE) begin
			wake_q   <= wake_d;
			nmi_q    <= nmi_d;
			resume_q <= resume_d;
			sleep_q  <= sleep_d;
			vector_q <= vector_q;
		end
	end

	// Scratch memory mapping for helper core and for other masters
	logic          aux_hit, sys_hit;
	logic [BW-1:0] aux_bank, sys_bank;
	logic [BANK_AW-1:0] aux_ofs, sys_ofs;

	acsl_scratch_map #(
		.BANKS   (BANKS),
		.BANK_AW (BANK_AW)
	) u_map_aux (
		.addr     (AUX_MEM_ADDR),
		.req      (AUX_MEM_REQ),
		.from_aux (1'b1),
		.hit      (aux_hit),
		.bank     (aux_bank),
		.offset   (aux_ofs)
	);

	acsl_scratch_map #(
		.BANKS   (BANKS),
		.BANK_AW (BANK_AW)
	) u_map_sys (
		.addr     (SYS_MEM_ADDR),
		.req      (SYS_MEM_REQ),
		.from_aux (1'b0),
		.hit      (sys_hit),
		.bank     (sys_bank),
		.offset   (sys_ofs)
	);

	logic               m_aux_hit_q, m_aux_hit_d;
	logic               m_sys_hit_q, m_sys_hit_d;
	logic               m_stall_q, m_stall_d;
	logic [BW-1:0]      m_aux_bank_q, m_aux_bank_d;
	logic [BW-1:0]      m_sys_bank_q, m_sys_bank_d;
	logic [BANK_AW-1:0] m_aux_ofs_q, m_aux_ofs_d;
	logic [BANK_AW-1:0] m_sys_ofs_q, m_sys_ofs_d;

	always_comb begin
		m_aux_hit_d  = aux_hit;
		m_aux_bank_d = aux_bank;
		m_aux_ofs_d  = aux_ofs;
		m_sys_bank_d = sys_bank;
		m_sys_ofs_d  = sys_ofs;
		// Only a same-bank collision serialises; the helper core has priority
		m_stall_d    = sys_hit && aux_hit && (sys_bank == aux_bank);
		m_sys_hit_d  = sys_hit && !m_stall_d;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			m_aux_hit_q  <= 1'b0;
			m_sys_hit_q  <= 1'b0;
			m_stall_q    <= 1'b0;
			m_aux_bank_q <= '0;
			m_sys_bank_q <= '0;
			m_aux_ofs_q  <= '0;
			m_sys_ofs_q  <= '0;
		end else if (CE) begin
			m_aux_hit_q  <= m_aux_hit_d;
			m_sys_hit_q  <= m_sys_hit_d;
			m_stall_q    <= m_stall_d;
			m_aux_bank_q <= m_aux_bank_d;
			m_sys_bank_q <= m_sys_bank_d;
			m_aux_ofs_q  <= m_aux_ofs_d;
			m_sys_ofs_q  <= m_sys_ofs_d;
		end
	end

	assign HRDATA          = rdata_q;
	assign HREADYOUT       = hready_q;
	assign HRESP           = hresp_q;
	assign AUX_RESET       = soft_reset_q;
	assign AUX_WAKE        = wake_q;
	assign AUX_NMI         = nmi_q;
	assign AUX_RESUME_NEXT = resume_q;
	assign AUX_BOOT_VECTOR = vector_q;
	assign AUX_MEM_HIT     = m_aux_hit_q;
	assign AUX_MEM_BANK    = m_aux_bank_q;
	assign AUX_MEM_OFFSET  = m_aux_ofs_q;
	assign SYS_MEM_HIT     = m_sys_hit_q;
	assign SYS_MEM_STALL   = m_stall_q;
	assign SYS_MEM_BANK    = m_sys_bank_q;
	assign SYS_MEM_OFFSET  = m_sys_ofs_q;

endmodule
`default_nettype wire

//--- bench/acsl_aux_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acsl_aux_ctrl_chk #(
	parameter int BANKS = 4
) (
	input wire logic			SYS_CLK,
	input wire logic			RST,
	input wire logic			CE,
	input wire logic			HSEL,
	input wire logic [31:0]			HADDR,
	input wire logic [1:0]			HTRANS,
	input wire logic			HWRITE,
	input wire logic [31:0]			HWDATA,
	input wire logic			HREADY,
	input wire logic			HREADYOUT,
	input wire logic			HRESP,
	input wire logic			AUX_RESET,
	input wire logic			AUX_WAKE,
	input wire logic			AUX_NMI,
	input wire logic			AUX_RESUME_NEXT,
	input wire logic [31:0]			AUX_BOOT_VECTOR,
	input wire logic			AUX_MEM_REQ,
	input wire logic [31:0]			AUX_MEM_ADDR,
	input wire logic			AUX_MEM_HIT,
	input wire logic [$clog2(BANKS)-1:0]	AUX_MEM_BANK,
	input wire logic			SYS_MEM_REQ,
	input wire logic [31:0]			SYS_MEM_ADDR,
	input wire logic			SYS_MEM_HIT
);
	logic	take;
	logic	wc_d;
	logic	wc_q;
	assign take = HSEL & HREADY & HTRANS[1] & CE;
	always_comb wc_d = take & HWRITE & (HADDR == 32'h1380_0000);
	// Marks the data phase of a control write, when HWDATA is valid
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			wc_q <= 1'b0;
		else if (CE)
			wc_q <= wc_d;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	pulse_wake_a: assert property (wc_q && HWDATA[1] |=> AUX_WAKE)
		else $error("wake pulse missing");
	wake_cause_a: assert property (AUX_WAKE |-> $past(wc_q && HWDATA[1]))
		else $error("wake pulse without a write");
	nmi_gate_a: assert property (wc_q && HWDATA[1] |=> AUX_NMI == !$past(HWDATA[2]))
		else $error("exception pulse wrong");
	resume_gate_a: assert property (AUX_RESUME_NEXT |-> AUX_WAKE && !AUX_NMI)
		else $error("resume pulse wrong");
	soft_reset_a: assert property (wc_q |=> AUX_RESET == $past(HWDATA[0]))
		else $error("core reset not written");
	reset_hold_a: assert property (!wc_q |=> $stable(AUX_RESET))
		else $error("core reset moved");
	boot_vec_a: assert property (AUX_BOOT_VECTOR == 32'hF400_8000)
		else $error("start address wrong");
	ok_resp_a: assert property (take && HADDR[31:4] == 28'h1380_000 && HADDR[1:0] == 2'h0
		|=> HREADYOUT && !HRESP)
		else $error("mapped access refused");
	err_resp_a: assert property (take && HADDR[31:4] != 28'h1380_000
		|=> !HREADYOUT && HRESP ##1 HREADYOUT && HRESP)
		else $error("unmapped access accepted");
	local_only_a: assert property (SYS_MEM_REQ && SYS_MEM_ADDR[31:15] == 17'h1_E800
		|=> !SYS_MEM_HIT)
		else $error("local window open to others");
	bank_map_a: assert property (AUX_MEM_REQ && AUX_MEM_ADDR[31:15] == 17'h1_E800
		|=> AUX_MEM_HIT && AUX_MEM_BANK == $past(AUX_MEM_ADDR[14:13]))
		else $error("local bank wrong");
	phys_hit_a: assert property (SYS_MEM_REQ && SYS_MEM_ADDR[31:15] == 17'h0_2701 && !AUX_MEM_REQ
		|=> SYS_MEM_HIT)
		else $error("physical window missed");
endmodule
bind acsl_aux_ctrl acsl_aux_ctrl_chk #(.BANKS(BANKS)) acsl_aux_ctrl_chk_i (.*);
`default_nettype wire

//--- bench/acsl_helper_model.sv
`timescale 1ns/1ps
`default_nettype none
module acsl_helper_model (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	core_rst,
	input wire logic	wake,
	input wire logic	go_wait,
	output logic		wait_exec,
	output logic		asleep
);
	// A sleeping core executes no further wait until woken
	always_ff @(posedge clk) begin
		if (rst || core_rst) begin
			wait_exec <= 1'b0;
			asleep <= 1'b0;
		end else begin
			wait_exec <= go_wait && !asleep;
			if (wait_exec)
				asleep <= 1'b1;
			else if (wake)
				asleep <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- bench/acsl_aux_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "acsl_consts.svh"
module acsl_aux_ctrl_tb;
	localparam logic [31:0] C = `ACSL_REG_BASE;
	localparam logic [31:0] L = C + 32'h0000_0004;
	localparam logic [31:0] T1 = C + 32'h0000_0008;
	localparam logic [31:0] T2 = C + 32'h0000_000C;
	logic SYS_CLK = 1'b0;
	logic RST, CE, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, AUX_WAIT_EXEC, AUX_RESET;
	logic AUX_WAKE, AUX_NMI, AUX_RESUME_NEXT, AUX_MEM_REQ, SYS_MEM_REQ, go_wait, asleep;
	logic AUX_MEM_HIT, SYS_MEM_HIT, SYS_MEM_STALL;
	logic [1:0] HTRANS, AUX_MEM_BANK, SYS_MEM_BANK;
	logic [2:0] HSIZE;
	logic [12:0] AUX_MEM_OFFSET, SYS_MEM_OFFSET;
	logic [31:0] HADDR, HWDATA, HRDATA, AUX_BOOT_VECTOR, AUX_MEM_ADDR, SYS_MEM_ADDR;
	logic [31:0] aa[4] = '{32'hF400_2004, 32'hF400_2000, 32'hF400_4000, 32'hF400_0000};
	logic [31:0] sa[4] = '{32'h1380_C008, 32'hF400_A010, 32'hF400_0000, 32'h1380_E00C};
	logic [1:0] hs[4] = '{2'b10, 2'b01, 2'b00, 2'b10};
	logic rq[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
	int miscompares = 0;
	int checks = 0;
	int i;
	always #5 SYS_CLK = ~SYS_CLK;
	assign HREADY = HREADYOUT;
	acsl_aux_ctrl acsl_aux_ctrl_i (.*);
	acsl_helper_model acsl_helper_model_i (
		.clk		(SYS_CLK),
		.rst		(RST),
		.core_rst	(AUX_RESET),
		.wake		(AUX_WAKE),
		.go_wait	(go_wait),
		.wait_exec	(AUX_WAIT_EXEC),
		.asleep		(asleep)
	);
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			input logic [31:0] exp, input logic experr);
		int n;
		@(posedge SYS_CLK) #1;
		HSEL = 1'b1;
		HTRANS = 2'b10;
		HWRITE = wr;
		HADDR = a;
		@(posedge SYS_CLK) #1;
		HSEL = 1'b0;
		HTRANS = 2'b00;
		HWDATA = wd;
		chk($sformatf("resp %h", a), 32'(experr), 32'(HRESP));
		for (n = 0; n < 4 && HREADYOUT !== 1'b1; n++)
			@(posedge SYS_CLK) #1;
		if (HREADYOUT !== 1'b1) begin
			miscompares++;
			report_and_stop();
		end
		if (!wr && !experr)
			chk($sformatf("rdata %h", a), exp, HRDATA);
	endtask
	// Called right after a control write: the pulses stand in the cycle after its data phase
	task automatic pulse_chk(input logic [2:0] exp);
		@(posedge SYS_CLK) #1;
		chk("wake nmi resume", 32'(exp), 32'({AUX_WAKE, AUX_NMI, AUX_RESUME_NEXT}));
	endtask
	initial begin
		{RST, CE, HSEL, HWRITE, HTRANS, HSIZE} = {1'b1, 1'b1, 2'b00, 2'b00, 3'b010};
		{HADDR, HWDATA, AUX_MEM_ADDR, SYS_MEM_ADDR} = '0;
		{AUX_MEM_REQ, SYS_MEM_REQ, go_wait} = '0;
		repeat (4) @(posedge SYS_CLK);
		#1 RST = 1'b0;
		chk("vector", 32'hF400_8000, AUX_BOOT_VECTOR);
		chk("core reset", 32'h0000_0001, 32'(AUX_RESET));
		acc(1'b0, C, 0, 32'h0000_0001, 1'b0);
		acc(1'b1, C, 32'hFFFF_FFFC, 0, 1'b0);
		pulse_chk(3'b000);
		chk("core reset", 32'h0000_0000, 32'(AUX_RESET));
		acc(1'b0, C, 0, 32'h0000_0004, 1'b0);
		go_wait = 1'b1;
		@(posedge SYS_CLK) #1;
		go_wait = 1'b0;
		acc(1'b0, C, 0, 32'h8000_0004, 1'b0);
		acc(1'b1, C, 32'h0000_0006, 0, 1'b0);
		pulse_chk(3'b101);
		acc(1'b0, C, 0, 32'h0000_0004, 1'b0);
		acc(1'b1, C, 32'h0000_0002, 0, 1'b0);
		pulse_chk(3'b110);
		acc(1'b0, C, 0, 32'h0000_0000, 1'b0);
		acc(1'b1, T1, 32'h0000_0001, 0, 1'b0);
		acc(1'b1, T2, 32'h0000_0002, 0, 1'b0);
		acc(1'b0, L, 0, 32'h0000_0000, 1'b0);
		acc(1'b0, T1, 0, 32'h0000_0001, 1'b0);
		acc(1'b0, T2, 0, 32'h0000_0001, 1'b0);
		acc(1'b1, L, 32'h0000_0000, 0, 1'b0);
		acc(1'b0, T2, 0, 32'h0000_0002, 1'b0);
		acc(1'b0, C + 32'h0000_0010, 0, 0, 1'b1);
		acc(1'b0, 32'h1390_0000, 0, 0, 1'b1);
		// Both masters request together in the first three steps so bank sharing is exercised
		for (i = 0; i < 4; i++) begin
			@(posedge SYS_CLK) #1;
			{AUX_MEM_REQ, SYS_MEM_REQ, AUX_MEM_ADDR, SYS_MEM_ADDR} = {rq[i], 1'b1, aa[i], sa[i]};
			@(posedge SYS_CLK) #1;
			chk("sys hit stall", 32'(hs[i]), 32'({SYS_MEM_HIT, SYS_MEM_STALL}));
			chk("aux hit", 32'(rq[i]), 32'(AUX_MEM_HIT));
			chk("sys bank", 32'(sa[i][14:13]), 32'(SYS_MEM_BANK));
			chk("sys offset", 32'(sa[i][12:0]), 32'(SYS_MEM_OFFSET));
			chk("aux bank", 32'(aa[i][14:13]), 32'(AUX_MEM_BANK));
			chk("aux offset", 32'(aa[i][12:0]), 32'(AUX_MEM_OFFSET));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
